/* File: hw/cvr_consts.vh */
// constants of the converter register bank
`ifndef CVR_CONSTS_VH
`define CVR_CONSTS_VH
`define CVR_ADDR_IDENT   8'h00
`define CVR_ADDR_SPARE   8'h01
`define CVR_ADDR_CEIL    8'h02
`define CVR_ADDR_RSVLO   8'h03
`define CVR_ADDR_FAULT   8'h04
`define CVR_ADDR_SETUP   8'h05
`define CVR_ADDR_RAMP    8'h06
`define CVR_ADDR_TARGET  8'h07
`define CVR_ADDR_RSVHI   8'h2B
`define CVR_RST_SPARE    8'h00
`define CVR_RST_RSVLO    8'h02
`define CVR_RST_RSVHI    8'h00
`define CVR_RST_ZERO     8'h00
`define CVR_CODE_MSB     6
`define CVR_FLT_INTERNAL 7
`define CVR_FLT_TRACK    6
`define CVR_FLT_THERMAL  5
`define CVR_FLT_BELOW    4
`define CVR_FLT_ABOVE    3
`define CVR_FLT_OVERCUR  2
`define CVR_FLT_CEILING  1
`define CVR_SETUP_STEP   7
`define CVR_SETUP_FORCED 3
`define CVR_SETUP_SPREAD 2
`define CVR_RAMP_MSB     3
`endif

/* File: hw/cvr_register_bank.v */
// register bank of the step-down converter with ceiling check
//
// Summary of operation
// RULE_01: address 00 reads fixed device code high nibble, revision code low nibble.
// RULE_02: addresses 00..07 and 2B decode as bytes; identity and status read-only.
// RULE_03: ceiling code is bits 6:0 of address 02, loaded from factory settings.
// RULE_04: requested code above ceiling raises fault and regulator gets the ceiling code.
// RULE_05: reserved bytes 03 and 2B reset to 02 and 00, no meaning.
// RULE_06: thermal and overcurrent flags stay set until the status register is read.
// RULE_07: ceiling error status bit reads one while request exceeds ceiling.
// RULE_08: step-size bit selects 10mV (0) or 12.5mV (1) per code step.
// RULE_09: writes to read-only locations change nothing; undecoded bits read zero.
//
// register map, offset then contents
// 00 identity: device code in 7:4, revision code in 3:0, read-only
// 01 spare byte, read and write
// 02 ceiling code in 6:0, read and write, loaded from factory settings
// 03 reserved low byte, read and write, no meaning to the host
// 04 status flags, read-only; a read clears the two sticky bits
// 05 converter settings: step size 7, forced pulse width 3, spread 2, sync 1:0
// 06 ramp rate code in 3:0, read and write, loaded from factory settings
// 07 requested voltage code in 6:0, read and write, loaded from factory settings
// 2B reserved high byte, read and write, no meaning to the host
//
// limitation: factory registers read zero until the load strobe arrives, so
// the fuse reader must pulse the strobe before the host is let onto the bus
`include "cvr_consts.vh"

module cvr_register_bank #(
  parameter [3:0] DEVICE_CODE   = 4'hA,  // arbitrary neutral value
  parameter [3:0] REVISION_CODE = 4'h5   // arbitrary neutral value
) (
  input  wire       ref_clk_in,
  input  wire       rst_in,
  // factory settings, taken while the load strobe is high
  input  wire       otp_load_in,
  input  wire [6:0] otp_ceiling_in,
  input  wire [7:0] otp_setup_in,
  input  wire [3:0] otp_ramp_in,
  input  wire [6:0] otp_target_in,
  // host register access, one byte per request
  input  wire       wr_en_in,
  input  wire       rd_en_in,
  input  wire [7:0] addr_in,
  input  wire [7:0] wdata_in,
  // events and live levels from the regulator
  input  wire       thermal_event_in,
  input  wire       overcurrent_event_in,
  input  wire       below_target_in,
  input  wire       above_target_in,
  input  wire       tracking_fault_in,
  input  wire       internal_fault_in,
  // read side, answered one cycle after the request
  output reg  [7:0] rdata_out,
  output reg        rdata_valid_out,
  // regulator side, levels that follow the stored state
  output reg  [6:0] applied_code_out,
  output reg        ceiling_fault_out,
  output reg        step_size_select_out,
  output reg        forced_pulse_width_select_out,
  output reg        spread_enable_out,
  output reg  [1:0] sync_mode_out,
  output reg  [3:0] ramp_rate_code_out
);

  // stored registers
  reg  [7:0] spare_byte;
  reg  [6:0] ceiling_code_field;
  reg  [7:0] reserved_low_byte;
  reg  [7:0] converter_settings;
  reg  [3:0] ramp_rate_code;
  reg  [6:0] requested_voltage_code;
  reg  [7:0] reserved_high_byte;
  // sticky status bits
  reg        thermal_trip_flag;
  reg        overcurrent_flag;
  // combinational helpers
  reg  [7:0] next_rdata;
  wire       ceiling_error_flag;
  wire [7:0] status_view;
  wire       status_read;

  // compare is combinational so the cap follows every write at once
  // RULE_07 ceiling error compare
  assign ceiling_error_flag = (requested_voltage_code > ceiling_code_field);
  // only a read of the status address clears the sticky bits
  assign status_read = rd_en_in && (addr_in == `CVR_ADDR_FAULT);

  // status bit layout, high to low:
  //   7 internal fault, live level
  //   6 tracking fault, live level
  //   5 thermal trip, sticky until a status read
  //   4 below target, live level
  //   3 above target, live level
  //   2 overcurrent, sticky until a status read
  //   1 ceiling error, live compare
  //   0 always zero
  // status byte assembled from live levels and sticky flags, bit 0 fixed zero
  assign status_view = {internal_fault_in, tracking_fault_in, thermal_trip_flag,
                        below_target_in, above_target_in, overcurrent_flag,
                        ceiling_error_flag, 1'b0};

  // writable registers; factory load overrides a same-cycle host write
  // RULE_03 ceiling register storage
  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      // factory registers start at zero until the load strobe
      spare_byte             <= `CVR_RST_SPARE;
      ceiling_code_field     <= 7'h00;
      // RULE_05 reserved reset values
      reserved_low_byte      <= `CVR_RST_RSVLO;
      reserved_high_byte     <= `CVR_RST_RSVHI;
      converter_settings     <= `CVR_RST_ZERO;
      ramp_rate_code         <= 4'h0;
      requested_voltage_code <= 7'h00;
    end
    else if (otp_load_in)
    begin
      // spare and reserved bytes have no factory value
      ceiling_code_field     <= otp_ceiling_in;
      converter_settings     <= otp_setup_in;
      ramp_rate_code         <= otp_ramp_in;
      requested_voltage_code <= otp_target_in;
    end
    else if (wr_en_in)
    begin
      // RULE_02 write decode
      // RULE_09 read-only addresses fall through
      if (addr_in == `CVR_ADDR_SPARE)
        spare_byte <= wdata_in;
      else if (addr_in == `CVR_ADDR_CEIL)
        ceiling_code_field <= wdata_in[`CVR_CODE_MSB:0];
      else if (addr_in == `CVR_ADDR_RSVLO)
        reserved_low_byte <= wdata_in;
      else if (addr_in == `CVR_ADDR_SETUP)
        converter_settings <= wdata_in;
      else if (addr_in == `CVR_ADDR_RAMP)
        ramp_rate_code <= wdata_in[`CVR_RAMP_MSB:0];
      else if (addr_in == `CVR_ADDR_TARGET)
        requested_voltage_code <= wdata_in[`CVR_CODE_MSB:0];
      else if (addr_in == `CVR_ADDR_RSVHI)
        reserved_high_byte <= wdata_in;
    end
  end

  // the set term comes first so an event is never lost to a clear
  // sticky flags; an event in the clearing cycle wins over the read clear
  // RULE_06 sticky clear on read
  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      thermal_trip_flag <= 1'b0;
      overcurrent_flag  <= 1'b0;
    end
    else
    begin
      thermal_trip_flag <= thermal_event_in | (thermal_trip_flag & ~status_read);
      overcurrent_flag  <= overcurrent_event_in | (overcurrent_flag & ~status_read);
    end
  end

  // read mux; unmapped addresses and unused bits return zero
  always @*
  begin
    next_rdata = 8'h00;
    // RULE_01 identity readback
    if (addr_in == `CVR_ADDR_IDENT)
      next_rdata = {DEVICE_CODE, REVISION_CODE};
    else if (addr_in == `CVR_ADDR_SPARE)
      next_rdata = spare_byte;
    // reserved bytes read back whole; the host must not rely on them
    else if (addr_in == `CVR_ADDR_CEIL)
      next_rdata = {1'b0, ceiling_code_field};
    else if (addr_in == `CVR_ADDR_RSVLO)
      next_rdata = reserved_low_byte;
    else if (addr_in == `CVR_ADDR_FAULT)
      next_rdata = status_view;
    else if (addr_in == `CVR_ADDR_SETUP)
      next_rdata = converter_settings;
    else if (addr_in == `CVR_ADDR_RAMP)
      next_rdata = {4'h0, ramp_rate_code};
    else if (addr_in == `CVR_ADDR_TARGET)
      next_rdata = {1'b0, requested_voltage_code};
    else if (addr_in == `CVR_ADDR_RSVHI)
      next_rdata = reserved_high_byte;
  end

  // registered outputs, one cycle behind the stored state
  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rdata_out                     <= 8'h00;
      rdata_valid_out               <= 1'b0;
      applied_code_out              <= 7'h00;
      ceiling_fault_out             <= 1'b0;
      step_size_select_out          <= 1'b0;
      forced_pulse_width_select_out <= 1'b0;
      spread_enable_out             <= 1'b0;
      sync_mode_out                 <= 2'h0;
      ramp_rate_code_out            <= 4'h0;
    end
    else
    begin
      // rdata holds between reads so a slow host can still pick it up
      rdata_valid_out <= rd_en_in;
      if (rd_en_in)
        rdata_out <= next_rdata;
      // the regulator only ever sees the lower of the two codes
      // RULE_04 cap to ceiling
      applied_code_out  <= ceiling_error_flag ? ceiling_code_field : requested_voltage_code;
      ceiling_fault_out <= ceiling_error_flag;
      // RULE_08 step size select
      step_size_select_out          <= converter_settings[`CVR_SETUP_STEP];
      // setting bits 3:0 pass to the switching control; bits 6:4 drive nothing
      forced_pulse_width_select_out <= converter_settings[`CVR_SETUP_FORCED];
      spread_enable_out             <= converter_settings[`CVR_SETUP_SPREAD];
      sync_mode_out                 <= converter_settings[1:0];
      ramp_rate_code_out            <= ramp_rate_code;
    end
  end

endmodule // cvr_register_bank

/* File: test/cvr_asserts.sv */
// checker for the converter register bank
module cvr_chk #(
  parameter [3:0] DEVICE_CODE   = 4'hA,
  parameter [3:0] REVISION_CODE = 4'h5
) (
  input wire       ref_clk_in,
  input wire       rst_in,
  input wire       rd_en_in,
  input wire [7:0] addr_in,
  input wire       thermal_event_in,
  input wire [7:0] rdata_out,
  input wire       rdata_valid_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // status read strobe, the only read with a side effect
  wire rs = rd_en_in && addr_in == 8'h04;
  property p_vld; rd_en_in |=> rdata_valid_out; endproperty
  a_vld: assert property (p_vld) else $error("no data strobe");
  property p_nov; !rd_en_in |=> !rdata_valid_out; endproperty
  a_nov: assert property (p_nov) else $error("stray data strobe");
  property p_id; rd_en_in && addr_in == 8'h00 |=> rdata_out == {DEVICE_CODE, REVISION_CODE};
  endproperty
  a_id: assert property (p_id) else $error("identity wrong");
  property p_und; rd_en_in && addr_in > 8'h07 && addr_in != 8'h2B |=> rdata_out == 8'h00;
  endproperty
  a_und: assert property (p_und) else $error("undecoded not zero");
  property p_c7; rd_en_in && addr_in == 8'h02 |=> !rdata_out[7]; endproperty
  a_c7: assert property (p_c7) else $error("ceiling bit 7 set");
  property p_s0; rs |=> !rdata_out[0]; endproperty
  a_s0: assert property (p_s0) else $error("status bit 0 set");
  property p_stk; thermal_event_in ##1 !rs ##1 rs |=> rdata_out[5]; endproperty
  a_stk: assert property (p_stk) else $error("thermal flag lost");
  property p_clr; rs && !thermal_event_in ##1 (!thermal_event_in) [*2] ##1 rs |=> !rdata_out[5];
  endproperty
  a_clr: assert property (p_clr) else $error("thermal flag not cleared");
endmodule // cvr_chk
bind cvr_register_bank cvr_chk #(.DEVICE_CODE(DEVICE_CODE), .REVISION_CODE(REVISION_CODE))
  u_chk (.ref_clk_in, .rst_in, .rd_en_in, .addr_in, .thermal_event_in, .rdata_out,
  .rdata_valid_out);

/* File: test/cvr_host.sv */
// host model issuing single-byte register accesses
module cvr_host (
  input  wire       clk_in,
  input  wire [7:0] rdata_in,
  output reg        wr_en_out = 1'b0,
  output reg        rd_en_out = 1'b0,
  output reg  [7:0] addr_out  = 8'h00,
  output reg  [7:0] wdata_out = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  // released lines show the inverse, so a stale value never looks live
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in) {wr_en_out, addr_out, wdata_out} <= {1'b1, a, d};
    @(posedge clk_in) {wr_en_out, addr_out, wdata_out} <= {1'b0, ~a, ~d};
  endtask
  // data is taken one edge after the request is taken
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in) {rd_en_out, addr_out} <= {1'b1, a};
    @(posedge clk_in) {rd_en_out, addr_out} <= {1'b0, ~a};
    @(posedge clk_in) d = rdata_in;
  endtask
endmodule // cvr_host

/* File: test/tb.sv */
// self-checking bench of the converter register bank
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 0, rst = 1, ld = 0, th = 0, oc = 0, wr, rd, vld, flt, stp, fpw, spr;
  logic [1:0] syn;
  logic [3:0] lv = 0, rmp = 0, rmpc;
  logic [6:0] cl = 0, tg = 0, app;
  logic [7:0] st = 0, a, wd, rdat, d;
  int         mismatches = 0, n_checks = 0;
  always #10 clk = ~clk;
  cvr_host host (.clk_in(clk), .rdata_in(rdat), .wr_en_out(wr), .rd_en_out(rd), .addr_out(a),
    .wdata_out(wd));
  // identity codes are arbitrary values
  cvr_register_bank #(.DEVICE_CODE(4'h6), .REVISION_CODE(4'h9)) dut (.ref_clk_in(clk),
    .rst_in(rst), .otp_load_in(ld), .otp_ceiling_in(cl), .otp_setup_in(st), .otp_ramp_in(rmp),
    .otp_target_in(tg), .wr_en_in(wr), .rd_en_in(rd), .addr_in(a), .wdata_in(wd),
    .thermal_event_in(th), .overcurrent_event_in(oc), .below_target_in(lv[0]),
    .above_target_in(lv[1]), .tracking_fault_in(lv[2]), .internal_fault_in(lv[3]),
    .rdata_out(rdat), .rdata_valid_out(vld), .applied_code_out(app), .ceiling_fault_out(flt),
    .step_size_select_out(stp), .forced_pulse_width_select_out(fpw), .spread_enable_out(spr),
    .sync_mode_out(syn), .ramp_rate_code_out(rmpc));
  task chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // read a register and compare
  task rchk(input logic [7:0] ad, input logic [7:0] exp);
    host.rd(ad, d);
    chk(d, exp, $sformatf("reg %h", ad));
  endtask
  // settle two edges, then compare the regulator side
  task ochk(input logic [6:0] ea, input logic ef);
    repeat (2) @(posedge clk);
    #1 chk({1'b0, app}, {1'b0, ea}, "applied");
    chk({7'h0, flt}, {7'h0, ef}, "fault");
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog: the whole run needs about 1800 ns
  initial
  begin
    #20000 mismatches++;
    give_verdict;
  end
  // reset values, identity, reserved bytes
  task t_reset;
    rchk(8'h00, 8'h69);
    rchk(8'h01, 8'h00);
    rchk(8'h03, 8'h02);
    rchk(8'h2B, 8'h00);
    rchk(8'h04, 8'h00);
  endtask
  // factory load of ceiling, setup, ramp and target, then host rewrites
  task t_factory;
    @(posedge clk) {ld, cl, st, rmp, tg} <= {1'h1, 7'h40, 8'h8D, 4'h9, 7'h30};
    @(posedge clk) ld <= 0;
    ochk(7'h30, 0);
    chk({7'h0, stp}, 8'h01, "step");
    chk({4'h0, rmpc}, 8'h09, "ramp");
    chk({6'h0, fpw, spr}, 8'h03, "pulse spread");
    chk({6'h0, syn}, 8'h01, "sync");
    rchk(8'h02, 8'h40);
    rchk(8'h05, 8'h8D);
    host.wr(8'h05, 8'h0C);
    ochk(7'h30, 0);
    chk({7'h0, stp}, 8'h00, "step");
    chk({6'h0, fpw, spr}, 8'h03, "pulse spread");
    chk({6'h0, syn}, 8'h00, "sync");
    host.wr(8'h06, 8'hFF);
    rchk(8'h06, 8'h0F);
    chk({4'h0, rmpc}, 8'h0F, "ramp");
  endtask
  // request above the ceiling is capped
  task t_ceiling;
    host.wr(8'h07, 8'hD0);
    ochk(7'h40, 1);
    rchk(8'h04, 8'h02);
    rchk(8'h07, 8'h50);
    host.wr(8'h02, 8'hFF);
    ochk(7'h50, 0);
  endtask
  // read-only and undecoded places refuse writes
  task t_read_only;
    host.wr(8'h00, 8'hFF);
    host.wr(8'h04, 8'hFF);
    host.wr(8'h10, 8'hFF);
    rchk(8'h00, 8'h69);
    rchk(8'h04, 8'h00);
    rchk(8'h10, 8'h00);
  endtask
  // sticky flags survive until one status read
  task t_sticky;
    @(posedge clk) {th, oc, lv} <= 6'h3F;
    @(posedge clk) {th, oc} <= 2'h0;
    rchk(8'h04, 8'hFC);
    lv <= 4'h0;
    rchk(8'h04, 8'h00);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 0;
    t_reset;
    t_factory;
    t_ceiling;
    t_read_only;
    t_sticky;
    give_verdict;
  end
endmodule // tb
